/* File: logic/csp_pkg.sv */
// Constants, types and the fixed shutdown program of the shutdown and reset controller
//
// What this block does
// - Writing 0119h to 6Fh starts entry 25
// - Entries 25 to 39 power down; 39 ends
// - Whole shutdown program takes about 296 ms
// - Internal reset forces all logic except the dropped-write flag to defaults
// - Either supply low drives internal reset low
// - Control writes discarded while internal reset held
// - Defaults at release; host writes only afterwards
// - Reset held at least 9.5 microseconds
// - Supply below off threshold reasserts reset at once
// - Dips above off thresholds cause no reset
// - Busy flag high while program runs
package csp_pkg;

   // Timing figures in their own units
   localparam real CLOCK_MHZ       = 125.0;
   localparam real POR_MIN_US      = 9.5;
   localparam real DELAY_UNIT_US   = 62.5;
   localparam real SHUTDOWN_TYP_MS = 350.0;
   localparam real MCLK_REF_MHZ    = 12.288;

   // Least times round up to whole clock cycles
   localparam int POR_CYCLES  = int'($ceil(POR_MIN_US * CLOCK_MHZ));
   localparam int UNIT_CYCLES = int'($ceil(DELAY_UNIT_US * CLOCK_MHZ));

   // Control interface widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;

   // Register addresses
   localparam logic [7:0] ADDR_SEQ_CTRL    = 8'h6F;
   localparam logic [7:0] ADDR_BIAS        = 8'h04;
   localparam logic [7:0] ADDR_MIDRAIL     = 8'h05;
   localparam logic [7:0] ADDR_PHONES_PGA  = 8'h0E;
   localparam logic [7:0] ADDR_LINE_PGA    = 8'h0F;
   localparam logic [7:0] ADDR_DAC         = 8'h12;
   localparam logic [7:0] ADDR_CLOCKS      = 8'h16;
   localparam logic [7:0] ADDR_SERVO       = 8'h43;
   localparam logic [7:0] ADDR_PHONES_OUT  = 8'h5A;
   localparam logic [7:0] ADDR_LINE_OUT    = 8'h5E;
   localparam logic [7:0] ADDR_CHARGE_PUMP = 8'h62;

   // Register image slots, same order as the address table
   localparam int NUM_TARGETS = 10;
   typedef logic [3:0] csp_idx_t;
   localparam csp_idx_t IDX_BIAS        = 4'h0;
   localparam csp_idx_t IDX_MIDRAIL     = 4'h1;
   localparam csp_idx_t IDX_PHONES_PGA  = 4'h2;
   localparam csp_idx_t IDX_LINE_PGA    = 4'h3;
   localparam csp_idx_t IDX_DAC         = 4'h4;
   localparam csp_idx_t IDX_CLOCKS      = 4'h5;
   localparam csp_idx_t IDX_SERVO       = 4'h6;
   localparam csp_idx_t IDX_PHONES_OUT  = 4'h7;
   localparam csp_idx_t IDX_LINE_OUT    = 4'h8;
   localparam csp_idx_t IDX_CHARGE_PUMP = 4'h9;
   localparam logic [7:0] TARGET_ADDR [NUM_TARGETS] = '{
      ADDR_BIAS, ADDR_MIDRAIL, ADDR_PHONES_PGA, ADDR_LINE_PGA, ADDR_DAC,
      ADDR_CLOCKS, ADDR_SERVO, ADDR_PHONES_OUT, ADDR_LINE_OUT, ADDR_CHARGE_PUMP};
   localparam logic [15:0] REG_DEFAULT = 16'h0000;

   // Sequencer control word fields
   localparam int SEQ_START_BIT = 8;
   localparam int SEQ_ABORT_BIT = 9;
   localparam int SEQ_IDX_MSB   = 6;
   localparam logic [6:0] SEQ_FIRST = 7'h19;
   localparam logic [6:0] SEQ_LAST  = 7'h27;

   // Delay code n waits (2^n + 8) units of 62.5 us
   localparam logic [15:0] DELAY_BASE_UNITS = 16'h0008;
   localparam logic [15:0] DELAY_ONE_UNIT   = 16'h0001;

   // Output bit positions
   localparam int BIT_SHORT_REL_L  = 7;
   localparam int BIT_OUT_STAGE_L  = 6;
   localparam int BIT_SERVO0       = 0;
   localparam int BIT_CHARGE_PUMP  = 0;
   localparam int BIT_DAC_L        = 3;
   localparam int BIT_DSP_CLOCK    = 1;
   localparam int BIT_BIAS         = 0;
   localparam int BIT_MID_REF      = 0;
   localparam int BIT_MID_BUF      = 6;
   localparam int MID_DIV_LSB      = 1;
   localparam int MID_DIV_MSB      = 2;

   // Sequencer states
   typedef enum logic [1:0] {
      SEQ_IDLE  = 2'b00,
      SEQ_WRITE = 2'b01,
      SEQ_WAIT  = 2'b10
   } csp_state_e;

   // One program entry
   typedef struct packed {
      logic [7:0] addr;
      logic [3:0] width;
      logic [3:0] start;
      logic [7:0] data;
      logic [3:0] delay;
      logic       end_of_sequence_flag;
   } csp_entry_s;

   localparam int PROG_LEN = 15;
   localparam csp_entry_s SHUTDOWN_PROG [PROG_LEN] = '{
      '{ADDR_LINE_OUT,    4'h8, 4'h0, 8'h77, 4'h0, 1'b0},
      '{ADDR_PHONES_OUT,  4'h8, 4'h0, 8'h77, 4'h0, 1'b0},
      '{ADDR_PHONES_OUT,  4'h8, 4'h0, 8'h00, 4'h0, 1'b0},
      '{ADDR_LINE_OUT,    4'h8, 4'h0, 8'h00, 4'h0, 1'b0},
      '{ADDR_SERVO,       4'h4, 4'h0, 8'h00, 4'h0, 1'b0},
      '{ADDR_CHARGE_PUMP, 4'h1, 4'h0, 8'h00, 4'h0, 1'b0},
      '{ADDR_DAC,         4'h2, 4'h2, 8'h00, 4'h0, 1'b0},
      '{ADDR_CLOCKS,      4'h1, 4'h1, 8'h00, 4'h0, 1'b0},
      '{ADDR_PHONES_PGA,  4'h2, 4'h0, 8'h00, 4'h0, 1'b0},
      '{ADDR_LINE_PGA,    4'h2, 4'h0, 8'h00, 4'h0, 1'b0},
      '{ADDR_BIAS,        4'h1, 4'h0, 8'h00, 4'h0, 1'b0},
      '{ADDR_MIDRAIL,     4'h1, 4'h0, 8'h00, 4'hC, 1'b0},
      '{ADDR_MIDRAIL,     4'h1, 4'h0, 8'h00, 4'h9, 1'b0},
      '{ADDR_MIDRAIL,     4'h8, 4'h0, 8'h00, 4'h0, 1'b0},
      '{ADDR_BIAS,        4'h2, 4'h0, 8'h00, 4'h0, 1'b1}};

endpackage

/* File: logic/csp_por_gen.sv */
// Internal power-on reset generator with minimum hold period
`timescale 1ns/1ps
module csp_por_gen #(
   parameter int HOLD_CYCLES = 1188
) (
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic analog_ok,
   input  wire logic core_ok,
   output logic      por_b_reg
);
   localparam int CNT_W = $clog2(HOLD_CYCLES + 1);

   logic [CNT_W-1:0] hold_cnt_reg;
   logic             supplies_ok;

   // Monitors report above the off threshold, so a shallow dip keeps this high
   assign supplies_ok = analog_ok & core_ok;

   // Hold reset low until both supplies have been good for the full period
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         hold_cnt_reg <= '0;
         por_b_reg    <= 1'b0;
      end
      else if (!supplies_ok)
      begin
         hold_cnt_reg <= '0;
         por_b_reg    <= 1'b0;
      end
      else if (!por_b_reg)
      begin
         // Counting from the first good cycle even with instant supply rise
         if (hold_cnt_reg == CNT_W'(HOLD_CYCLES - 1))
            por_b_reg <= 1'b1;
         else
            hold_cnt_reg <= hold_cnt_reg + CNT_W'(1);
      end
   end
endmodule

/* File: logic/csp_shutdown_ctrl.sv */
// Shutdown program sequencer, register image and reset gating of the codec control logic
`timescale 1ns/1ps
module csp_shutdown_ctrl #(
   parameter int UNIT_CYCLES = csp_pkg::UNIT_CYCLES
) (
   input  wire logic                       CLOCK,
   input  wire logic                       RST_B,
   input  wire logic                       ANALOG_SUPPLY_OK,
   input  wire logic                       CORE_SUPPLY_OK,
   input  wire logic                       CTRL_WRITE,
   input  wire logic [csp_pkg::ADDR_W-1:0] CTRL_ADDR,
   input  wire logic [csp_pkg::DATA_W-1:0] CTRL_DATA,
   output logic                            INTERNAL_RESET_B,
   output logic                            CTRL_WRITE_DROPPED,
   output logic                            SEQUENCER_BUSY_FLAG,
   output logic                            END_OF_SEQUENCE_FLAG,
   output logic [6:0]                      SEQ_INDEX,
   output logic                            LEFT_LINE_SHORT_RELEASE,
   output logic                            LEFT_PHONES_SHORT_RELEASE,
   output logic                            LEFT_PHONES_OUTPUT_STAGE_ON,
   output logic                            SERVO_CHANNEL0_ON,
   output logic                            CHARGE_PUMP_ON,
   output logic                            LEFT_DAC_ON,
   output logic                            DSP_CLOCK_ON,
   output logic                            BIAS_ON,
   output logic                            MIDRAIL_REFERENCE_ON,
   output logic                            MIDRAIL_BUFFER_ON,
   output logic [1:0]                      MIDRAIL_DIVIDER_SELECT
);
   import csp_pkg::*;

   localparam int CYC_W = $clog2(UNIT_CYCLES + 1);

   logic               por_b;
   logic               host_wr;
   logic               seq_ctrl_wr;
   logic               start_req;
   logic               abort_req;
   logic [6:0]         start_idx;
   logic               start_ok;
   logic [3:0]         prog_pos;
   csp_entry_s         entry;
   logic [15:0]        delay_units;
   logic               unit_tick;
   logic               wait_done;
   logic [4:0]         host_hit;
   logic [4:0]         seq_hit;
   logic [15:0]        seq_mask;
   logic [15:0]        seq_value;

   csp_state_e         state_reg;
   logic [6:0]         index_reg;
   logic               busy_reg;
   logic               eos_pulse_reg;
   logic               dropped_reg;
   logic [15:0]        unit_cnt_reg;
   logic [CYC_W-1:0]   cyc_cnt_reg;
   logic [15:0]        regs_reg [NUM_TARGETS];

   // Address to image slot; top bit flags a hit
   function automatic logic [4:0] target_slot(input logic [7:0] addr);
      logic [4:0] slot;
      slot = 5'h00;
      for (int i = 0; i < NUM_TARGETS; i++)
      begin
         if (TARGET_ADDR[i] == addr)
            slot = {1'b1, 4'(i)};
      end
      return slot;
   endfunction

   // Mask of a field of given width at given start bit
   function automatic logic [15:0] field_mask(input logic [3:0] width,
                                              input logic [3:0] start);
      logic [16:0] ones;
      ones = (17'h00001 << width) - 17'h00001;
      return ones[15:0] << start;
   endfunction

   // Internal power-on reset
   csp_por_gen #(
      .HOLD_CYCLES (POR_CYCLES)
   ) u_por (
      .clk       (CLOCK),
      .rst_b     (RST_B),
      .analog_ok (ANALOG_SUPPLY_OK),
      .core_ok   (CORE_SUPPLY_OK),
      .por_b_reg (por_b)
   );

   assign INTERNAL_RESET_B = por_b;

   // Host writes count only once the internal reset has released
   assign host_wr     = CTRL_WRITE & por_b;
   assign seq_ctrl_wr = host_wr && (CTRL_ADDR == ADDR_SEQ_CTRL);
   assign start_idx   = CTRL_DATA[SEQ_IDX_MSB:0];
   // Only the shutdown program is held here; other start indices are ignored
   assign start_ok    = (start_idx >= SEQ_FIRST) && (start_idx <= SEQ_LAST);
   assign abort_req   = seq_ctrl_wr && CTRL_DATA[SEQ_ABORT_BIT];
   assign start_req   = seq_ctrl_wr && CTRL_DATA[SEQ_START_BIT]
                        && !CTRL_DATA[SEQ_ABORT_BIT] && start_ok;

   // Current entry of the fixed program
   assign prog_pos    = 4'(index_reg - SEQ_FIRST);
   assign entry       = SHUTDOWN_PROG[prog_pos];
   assign delay_units = DELAY_BASE_UNITS + (DELAY_ONE_UNIT << entry.delay);

   // Delay timer strobes
   assign unit_tick = (cyc_cnt_reg == CYC_W'(UNIT_CYCLES - 1));
   assign wait_done = (state_reg == SEQ_WAIT) && unit_tick
                      && (unit_cnt_reg == DELAY_ONE_UNIT);

   // Field write of the current entry
   assign host_hit  = target_slot(CTRL_ADDR);
   assign seq_hit   = target_slot(entry.addr);
   assign seq_mask  = field_mask(entry.width, entry.start);
   assign seq_value = 16'({8'h00, entry.data} << entry.start) & seq_mask;

   // Sequencer state and index; an abort takes priority over everything except the resets
   always_ff @(posedge CLOCK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         state_reg <= SEQ_IDLE;
         index_reg <= SEQ_FIRST;
      end
      else if (!por_b)
      begin
         state_reg <= SEQ_IDLE;
         index_reg <= SEQ_FIRST;
      end
      else if (abort_req)
         state_reg <= SEQ_IDLE;
      else
      begin
         unique case (state_reg)
            SEQ_IDLE:
            begin
               if (start_req)
               begin
                  state_reg <= SEQ_WRITE;
                  index_reg <= start_idx;
               end
            end
            SEQ_WRITE:
               state_reg <= SEQ_WAIT;
            SEQ_WAIT:
            begin
               if (wait_done)
               begin
                  if (entry.end_of_sequence_flag)
                     state_reg <= SEQ_IDLE;
                  else
                  begin
                     state_reg <= SEQ_WRITE;
                     index_reg <= index_reg + 7'h01;
                  end
               end
            end
            default:
               state_reg <= SEQ_IDLE;
         endcase
      end
   end

   // Delay timer: prescaler to 62.5 us units, then units down to one
   always_ff @(posedge CLOCK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         cyc_cnt_reg  <= '0;
         unit_cnt_reg <= 16'h0000;
      end
      else if (!por_b || state_reg != SEQ_WAIT)
      begin
         cyc_cnt_reg  <= '0;
         unit_cnt_reg <= delay_units;
      end
      else if (unit_tick)
      begin
         cyc_cnt_reg  <= '0;
         unit_cnt_reg <= unit_cnt_reg - DELAY_ONE_UNIT;
      end
      else
         cyc_cnt_reg <= cyc_cnt_reg + CYC_W'(1);
   end

   // Busy covers the last entry's delay too
   always_ff @(posedge CLOCK or negedge RST_B)
   begin
      if (!RST_B)
         busy_reg <= 1'b0;
      else if (!por_b || abort_req)
         busy_reg <= 1'b0;
      else if (start_req && state_reg == SEQ_IDLE)
         busy_reg <= 1'b1;
      else if (wait_done && entry.end_of_sequence_flag)
         busy_reg <= 1'b0;
   end

   // One-cycle marker when the end entry completes
   always_ff @(posedge CLOCK or negedge RST_B)
   begin
      if (!RST_B)
         eos_pulse_reg <= 1'b0;
      else
         eos_pulse_reg <= por_b && !abort_req && wait_done && entry.end_of_sequence_flag;
   end

   // Flags a control write that arrived while held in reset
   always_ff @(posedge CLOCK or negedge RST_B)
   begin
      if (!RST_B)
         dropped_reg <= 1'b0;
      else
         dropped_reg <= CTRL_WRITE & ~por_b;
   end

   // Register image; sequencer field write lands after a same-cycle host write
   always_ff @(posedge CLOCK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         for (int i = 0; i < NUM_TARGETS; i++)
            regs_reg[i] <= REG_DEFAULT;
      end
      else if (!por_b)
      begin
         for (int i = 0; i < NUM_TARGETS; i++)
            regs_reg[i] <= REG_DEFAULT;
      end
      else
      begin
         for (int i = 0; i < NUM_TARGETS; i++)
         begin
            if (host_wr && host_hit[4] && host_hit[3:0] == 4'(i))
               regs_reg[i] <= CTRL_DATA;
            if (state_reg == SEQ_WRITE && seq_hit[4] && seq_hit[3:0] == 4'(i))
               regs_reg[i] <= (regs_reg[i] & ~seq_mask) | seq_value;
         end
      end
   end

   // Status and power-enable outputs straight from flip-flops
   assign SEQUENCER_BUSY_FLAG         = busy_reg;
   assign END_OF_SEQUENCE_FLAG        = eos_pulse_reg;
   assign CTRL_WRITE_DROPPED          = dropped_reg;
   assign SEQ_INDEX                   = index_reg;
   assign LEFT_LINE_SHORT_RELEASE     = regs_reg[IDX_LINE_OUT][BIT_SHORT_REL_L];
   assign LEFT_PHONES_SHORT_RELEASE   = regs_reg[IDX_PHONES_OUT][BIT_SHORT_REL_L];
   assign LEFT_PHONES_OUTPUT_STAGE_ON = regs_reg[IDX_PHONES_OUT][BIT_OUT_STAGE_L];
   assign SERVO_CHANNEL0_ON           = regs_reg[IDX_SERVO][BIT_SERVO0];
   assign CHARGE_PUMP_ON              = regs_reg[IDX_CHARGE_PUMP][BIT_CHARGE_PUMP];
   assign LEFT_DAC_ON                 = regs_reg[IDX_DAC][BIT_DAC_L];
   assign DSP_CLOCK_ON                = regs_reg[IDX_CLOCKS][BIT_DSP_CLOCK];
   assign BIAS_ON                     = regs_reg[IDX_BIAS][BIT_BIAS];
   assign MIDRAIL_REFERENCE_ON        = regs_reg[IDX_MIDRAIL][BIT_MID_REF];
   assign MIDRAIL_BUFFER_ON           = regs_reg[IDX_MIDRAIL][BIT_MID_BUF];
   assign MIDRAIL_DIVIDER_SELECT      = regs_reg[IDX_MIDRAIL][MID_DIV_MSB:MID_DIV_LSB];

endmodule

/* File: dv/csp_shutdown_ctrl_chk.sv */
// Port checker for reset gating and shutdown sequencing
`timescale 1ns/1ps
module csp_shutdown_ctrl_chk #(
   parameter int UNIT_CYCLES = 4
) (
   input wire logic                       CLOCK,
   input wire logic                       RST_B,
   input wire logic                       ANALOG_SUPPLY_OK,
   input wire logic                       CORE_SUPPLY_OK,
   input wire logic                       CTRL_WRITE,
   input wire logic [csp_pkg::ADDR_W-1:0] CTRL_ADDR,
   input wire logic [csp_pkg::DATA_W-1:0] CTRL_DATA,
   input wire logic                       INTERNAL_RESET_B,
   input wire logic                       CTRL_WRITE_DROPPED,
   input wire logic                       SEQUENCER_BUSY_FLAG,
   input wire logic                       END_OF_SEQUENCE_FLAG,
   input wire logic [6:0]                 SEQ_INDEX,
   input wire logic                       BIAS_ON,
   input wire logic                       CHARGE_PUMP_ON,
   input wire logic                       MIDRAIL_REFERENCE_ON
);
   import csp_pkg::*;
   int         low_cnt;
   int         gap_cnt;
   logic [6:0] idx_reg;
   logic       moved;

   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_B);

   // Length of the present internal reset
   always_ff @(posedge CLOCK or negedge RST_B)
      if (!RST_B) low_cnt <= 0;
      else low_cnt <= INTERNAL_RESET_B ? 0 : low_cnt + 1;

   // Cycles since the entry index last moved; a real counter avoids long repetitions
   always_ff @(posedge CLOCK or negedge RST_B)
      if (!RST_B)
      begin
         gap_cnt <= 0;
         idx_reg <= 7'h19;
      end
      else
      begin
         gap_cnt <= (SEQ_INDEX != idx_reg) ? 0 : gap_cnt + 1;
         idx_reg <= SEQ_INDEX;
      end
   assign moved = SEQUENCER_BUSY_FLAG && (SEQ_INDEX != idx_reg);

   sequence s_start_req;
      CTRL_WRITE && INTERNAL_RESET_B && !SEQUENCER_BUSY_FLAG
         && CTRL_ADDR == 8'h6F && CTRL_DATA == 16'h0119;
   endsequence
   sequence s_busy_up;
      SEQUENCER_BUSY_FLAG && SEQ_INDEX == 7'h19 ##1 SEQUENCER_BUSY_FLAG;
   endsequence
   property p_start;
      s_start_req |=> s_busy_up;
   endproperty

   a_start_runs: assert property (p_start)
      else $error("start write ignored");
   a_supply_low_rst: assert property ((!ANALOG_SUPPLY_OK || !CORE_SUPPLY_OK)
      |=> !INTERNAL_RESET_B) else $error("reset not asserted on low supply");
   a_no_dip_rst: assert property ($fell(INTERNAL_RESET_B) |->
      !$past(ANALOG_SUPPLY_OK) || !$past(CORE_SUPPLY_OK)) else $error("spurious reset");
   a_reset_min_hold: assert property ($rose(INTERNAL_RESET_B) |->
      low_cnt >= POR_CYCLES) else $error("reset released early");
   a_reset_clears: assert property (!INTERNAL_RESET_B |=> !(BIAS_ON || CHARGE_PUMP_ON
      || MIDRAIL_REFERENCE_ON || SEQUENCER_BUSY_FLAG)) else $error("state kept in reset");
   a_write_dropped: assert property (CTRL_WRITE && !INTERNAL_RESET_B
      |=> CTRL_WRITE_DROPPED) else $error("write in reset not flagged");
   a_write_lands: assert property (CTRL_WRITE && INTERNAL_RESET_B && CTRL_ADDR == 8'h04
      && !SEQUENCER_BUSY_FLAG |=> BIAS_ON == $past(CTRL_DATA[0]))
      else $error("host write lost");
   a_index_step: assert property (moved && $past(SEQUENCER_BUSY_FLAG)
      |-> SEQ_INDEX == idx_reg + 7'h01) else $error("entry skipped");
   a_entry_wait: assert property (moved && $past(SEQUENCER_BUSY_FLAG)
      |-> gap_cnt >= 9 * UNIT_CYCLES) else $error("entry delay short");
   a_eos_at_end: assert property (END_OF_SEQUENCE_FLAG |->
      $fell(SEQUENCER_BUSY_FLAG) && SEQ_INDEX == 7'h27) else $error("bad end flag");
   a_eos_pulse: assert property (END_OF_SEQUENCE_FLAG |=> !END_OF_SEQUENCE_FLAG)
      else $error("end flag too long");
endmodule

/* File: dv/csp_host_model.sv */
// Host processor model issuing single-cycle control writes
`timescale 1ns/1ps
module csp_host_model (
   input  wire logic   clk,
   input  wire logic   internal_reset_b,
   output logic        ctrl_write,
   output logic [7:0]  ctrl_addr,
   output logic [15:0] ctrl_data
);
   initial
   begin
      ctrl_write = 1'b0;
      ctrl_addr  = 8'h00;
      ctrl_data  = 16'h0000;
   end

   // One write; early is set only where a scenario means to be refused
   // Released lines show the inverse so a stale address never passes for a live one
   task automatic wr(input logic [7:0] a, input logic [15:0] d, input bit early);
      if (!early) wait (internal_reset_b === 1'b1);
      @(posedge clk);
      #1;
      ctrl_write = 1'b1;
      ctrl_addr  = a;
      ctrl_data  = d;
      @(posedge clk);
      #1;
      ctrl_write = 1'b0;
      ctrl_addr  = ~a;
      ctrl_data  = ~d;
   endtask
endmodule

/* File: dv/test_codec_shutdown_and_por_control.sv */
// Self-checking bench for the shutdown sequencer and reset gating
`timescale 1ns/1ps
module test_codec_shutdown_and_por_control;
   import csp_pkg::*;
   localparam int UNIT = 4;
   // Whole program: 15 write cycles, 13 waits of 9 units, plus one wait of 4104 and one of 520 units
   localparam int T_PROG = 15 + (13 * 9 + 4104 + 520) * UNIT;
   logic        clk, rst_b, ana_ok, core_ok, wr, ir_b, drop, busy, end_of_sequence_flag;
   logic [7:0]  addr;
   logic [15:0] data;
   logic [6:0]  idx;
   logic        llsr, lpsr, lpos, servo, cp, dac, dsp, bias, mref, mbuf;
   logic [1:0]  mdiv;
   int          fails, total_checks;

   csp_host_model hm (.clk(clk), .internal_reset_b(ir_b), .ctrl_write(wr),
      .ctrl_addr(addr), .ctrl_data(data));

   csp_shutdown_ctrl #(.UNIT_CYCLES(UNIT)) DUT (.CLOCK(clk), .RST_B(rst_b),
      .ANALOG_SUPPLY_OK(ana_ok), .CORE_SUPPLY_OK(core_ok), .CTRL_WRITE(wr),
      .CTRL_ADDR(addr), .CTRL_DATA(data), .INTERNAL_RESET_B(ir_b),
      .CTRL_WRITE_DROPPED(drop), .SEQUENCER_BUSY_FLAG(busy), .END_OF_SEQUENCE_FLAG(end_of_sequence_flag),
      .SEQ_INDEX(idx), .LEFT_LINE_SHORT_RELEASE(llsr), .LEFT_PHONES_SHORT_RELEASE(lpsr),
      .LEFT_PHONES_OUTPUT_STAGE_ON(lpos), .SERVO_CHANNEL0_ON(servo),
      .CHARGE_PUMP_ON(cp), .LEFT_DAC_ON(dac), .DSP_CLOCK_ON(dsp), .BIAS_ON(bias),
      .MIDRAIL_REFERENCE_ON(mref), .MIDRAIL_BUFFER_ON(mbuf),
      .MIDRAIL_DIVIDER_SELECT(mdiv));

   always #4 clk = ~clk;

   function automatic logic [15:0] outs();
      return {4'h0, llsr, lpsr, lpos, servo, cp, dac, dsp, bias, mref, mbuf, mdiv};
   endfunction

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Count edges until the internal reset lets go, bounded
   task automatic wait_up(output int n);
      n = 0;
      do
      begin
         @(posedge clk);
         #1;
         n++;
      end while (ir_b !== 1'b1 && n < 3000);
   endtask

   task automatic t_por();
      int n;
      hm.wr(8'h04, 16'h0001, 1);
      chk(drop, 16'h1);
      wait_up(n);
      chk(ir_b, 16'h1);
      chk(16'(n + 2 >= POR_CYCLES), 16'h1);
      chk(outs(), 16'h0);
      chk(idx, 16'h19);
   endtask

   task automatic t_host();
      logic [7:0]  ha [8] = '{8'h5A, 8'h5E, 8'h43, 8'h62, 8'h12, 8'h16, 8'h04, 8'h05};
      logic [15:0] hd [8] = '{16'h00FF, 16'h00FF, 16'h000F, 16'h0001,
                              16'h000C, 16'h0002, 16'h0003, 16'h0047};
      for (int i = 0; i < 8; i++) hm.wr(ha[i], hd[i], 0);
      chk(outs(), 16'h0FFF);
   endtask

   task automatic t_shutdown();
      int n;
      bit m1, m2;
      n = 0;
      m1 = 0;
      m2 = 0;
      hm.wr(8'h6F, 16'h0119, 0);
      chk({busy, idx}, 16'h0099);
      while (end_of_sequence_flag !== 1'b1 && n < 30000)
      begin
         cyc(1);
         n++;
         if (idx == 7'h1B && !m1)
         begin
            m1 = 1;
            chk({lpsr, lpos}, 16'h1);
         end
         if (idx == 7'h26 && !m2)
         begin
            m2 = 1;
            chk({mref, mbuf, mdiv}, 16'h7);
         end
      end
      chk(16'(n), 16'(T_PROG));
      chk({busy, idx}, 16'h0027);
      chk(outs(), 16'h0);
   endtask

   // Abort mid-program, refused starts, then a lone run of the end entry
   task automatic t_abort();
      logic [15:0] bad [2] = '{16'h0100, 16'h0128};
      logic        e;
      int          n;
      e = 1'b0;
      n = 0;
      hm.wr(8'h6F, 16'h0119, 0);
      cyc(3);
      hm.wr(8'h6F, 16'h0200, 0);
      chk(busy, 16'h0);
      repeat (60)
      begin
         cyc(1);
         e |= end_of_sequence_flag;
      end
      chk(e, 16'h0);
      foreach (bad[i])
      begin
         hm.wr(8'h6F, bad[i], 0);
         chk(busy, 16'h0);
      end
      // Start at the end entry; its field write lands one edge later
      hm.wr(8'h04, 16'h0003, 0);
      hm.wr(8'h6F, 16'h0127, 0);
      chk({busy, idx, bias}, 16'h014F);
      // A start while busy must leave the running program alone
      hm.wr(8'h6F, 16'h0119, 0);
      chk({busy, idx}, 16'h00A7);
      while (end_of_sequence_flag !== 1'b1 && n < 100)
      begin
         cyc(1);
         n++;
      end
      chk(16'(n), 16'(9 * UNIT - 1));
      chk({busy, idx, bias}, 16'h004E);
   endtask

   task automatic t_supply();
      int n;
      for (int s = 0; s < 2; s++)
      begin
         hm.wr(8'h04, 16'h0001, 0);
         cyc(20);
         chk({ir_b, bias}, 16'h3);
         if (s == 0) ana_ok = 0;
         else core_ok = 0;
         cyc(1);
         chk(ir_b, 16'h0);
         cyc(1);
         chk(bias, 16'h0);
         hm.wr(8'h04, 16'h0001, 1);
         chk({drop, bias}, 16'h2);
         ana_ok = 1;
         core_ok = 1;
         wait_up(n);
         chk(ir_b, 16'h1);
         chk(16'(n >= POR_CYCLES), 16'h1);
         chk(bias, 16'h0);
      end
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial
   begin
      clk = 0;
      rst_b = 0;
      ana_ok = 1;
      core_ok = 1;
      repeat (20) @(posedge clk);
      #1 rst_b = 1;
      t_por();
      t_host();
      t_shutdown();
      t_abort();
      t_supply();
      final_report();
   end

   // Watchdog at about twice the expected run length
   initial
   begin
      #(50000 * 8);
      fails++;
      final_report();
   end
endmodule

bind csp_shutdown_ctrl csp_shutdown_ctrl_chk #(.UNIT_CYCLES(UNIT_CYCLES)) u_chk (
   .CLOCK(CLOCK), .RST_B(RST_B), .ANALOG_SUPPLY_OK(ANALOG_SUPPLY_OK),
   .CORE_SUPPLY_OK(CORE_SUPPLY_OK), .CTRL_WRITE(CTRL_WRITE), .CTRL_ADDR(CTRL_ADDR),
   .CTRL_DATA(CTRL_DATA), .INTERNAL_RESET_B(INTERNAL_RESET_B),
   .CTRL_WRITE_DROPPED(CTRL_WRITE_DROPPED), .SEQUENCER_BUSY_FLAG(SEQUENCER_BUSY_FLAG),
   .END_OF_SEQUENCE_FLAG(END_OF_SEQUENCE_FLAG), .SEQ_INDEX(SEQ_INDEX), .BIAS_ON(BIAS_ON),
   .CHARGE_PUMP_ON(CHARGE_PUMP_ON), .MIDRAIL_REFERENCE_ON(MIDRAIL_REFERENCE_ON));
